// file: shared/rcl_pkg.sv
// Contract
// - the threshold select register maps 8'h55 to 2.1V, 8'h33 to 2.55V, 8'h99 to 3.15V, 8'hAA to 3.8V.
// - any other threshold code gives a full reset two to three slow cycles later and restores 8'h55 (the delay fires after one to two).
// - a qualified low supply gives a full reset two to three slow cycles later, threshold kept (the delay fires after one to two).
// - a genuine low-voltage reset sets the undervoltage flag, which only a software zero clears.
// - a bad threshold code sets the bad-code flag as a software reset, only software clears it.
// - bits 7 to 4 of the reset-cause register always read zero.
// - a watchdog expiry in normal operation is a full reset like low voltage and also sets expiry.
// - a watchdog expiry in sleep or idle only clears program counter and stack pointer and sets expiry.
// - power-on clears expiry and power-down flags, low voltage keeps both, watchdog sets per mode.
// - power-on zeroes the program counter, disables interrupts, clears watchdog.
// - power-on turns timers off, makes ports inputs and points the stack pointer at the top.
// - a low supply counts only if it stays between 0.9V and the threshold longer than qualification.
// - the undervoltage reset is disabled while the device is powered down.
package rcl_pkg;

	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_THRESH = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_CAUSE = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h00C;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h010;

	localparam logic [7:0] CODE_2V10 = 8'h55;
	localparam logic [7:0] CODE_2V55 = 8'h33;
	localparam logic [7:0] CODE_3V15 = 8'h99;
	localparam logic [7:0] CODE_3V80 = 8'hAA;
	localparam logic [7:0] THRESH_POR = 8'h55;

	typedef enum logic [1:0] {
		TH_2V10 = 2'b00,
		TH_2V55 = 2'b01,
		TH_3V15 = 2'b10,
		TH_3V80 = 2'b11
	} rcl_level_t;

	// reset-cause bits; delayed request sources share the same indices
	localparam int NUM_SRC = 4;
	localparam int CAUSE_WDT_CODE = 0;
	localparam int CAUSE_BAD_CODE = 1;
	localparam int CAUSE_LVR = 2;
	localparam int CAUSE_CTRL_CODE = 3;
	localparam logic [3:0] CAUSE_POR = 4'h0;

	// status flag bits
	localparam int STAT_PDF = 0;
	localparam int STAT_TO = 1;

	// interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_LVR = 0;
	localparam int IRQ_BAD_CODE = 1;
	localparam int IRQ_WDT_RESET = 2;
	localparam int IRQ_WDT_WAKE = 3;

	// pin synchroniser lanes
	localparam int PIN_LOW = 0;
	localparam int PIN_ABOVE_MIN = 1;
	localparam int PIN_PD = 2;

	localparam int SLOW_DELAY_TICKS = 2;

	localparam int CLK_PERIOD_NS = 50;
	localparam int LVR_QUAL_NS = 100000;
	localparam int LVR_QUAL_CYCLES = (LVR_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_NS = 1000;
	localparam int HOLD_CYCLES = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic {
		ST_RUN = 1'b0,
		ST_HOLD = 1'b1
	} rcl_state_t;

endpackage

// file: shared/rcl_delay_if.sv
interface rcl_delay_if #(parameter int N = rcl_pkg::NUM_SRC);
	logic [N-1:0] req;
	logic slowTick;
	logic [N-1:0] fire;
	modport ctl(output req, output slowTick, input fire);
	modport dly(input req, input slowTick, output fire);
endinterface

// file: logic/rcl_slow_delay.sv
module rcl_slow_delay #(
	parameter int N = rcl_pkg::NUM_SRC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	rcl_delay_if.dly link
);
	import rcl_pkg::*;

	localparam logic [1:0] LAST_TICK = 2'(SLOW_DELAY_TICKS - 1);

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_src
			logic [1:0] cntReg;
			logic fireReg;
			// a request must survive two slow edges; arriving mid-period gives 1 to 2 periods
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					cntReg <= 2'h0;
				end else if (!link.req[i]) begin
					cntReg <= 2'h0;
				end else if (link.slowTick) begin
					cntReg <= (cntReg == LAST_TICK) ? 2'h0 : cntReg + 2'h1;
				end
			end
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					fireReg <= 1'b0;
				end else begin
					fireReg <= link.req[i] && link.slowTick && (cntReg == LAST_TICK);
				end
			end
			assign link.fire[i] = fireReg;
		end
	endgenerate

endmodule

// file: logic/rcl_reset_ctrl.sv
module rcl_reset_ctrl #(
	parameter int QUAL_CYCLES = rcl_pkg::LVR_QUAL_CYCLES,
	parameter int HOLD_LEN = rcl_pkg::HOLD_CYCLES
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rcl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lircIn,
	input wire logic supplyLow,
	input wire logic supplyAboveMin,
	input wire logic powerDown,
	input wire logic cpuIdle,
	input wire logic wdtExpire,
	input wire logic ctrlCodeFault,
	input wire logic wdtCodeFault,
	output rcl_pkg::rcl_level_t thresholdLevel,
	output logic coreReset,
	output logic pcClear,
	output logic spZero,
	output logic spTop,
	output logic intDisable,
	output logic timersOff,
	output logic portsInput,
	output logic wdtClear,
	output logic wdtRun,
	output logic irq
);
	import rcl_pkg::*;

	localparam int QUAL_W = $clog2(QUAL_CYCLES + 1);
	localparam int HOLD_W = $clog2(HOLD_LEN + 1);
	localparam logic [QUAL_W-1:0] QUAL_MAX = QUAL_W'(QUAL_CYCLES);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_LEN - 1);

	// returns {valid, level} for a threshold code
	function automatic logic [2:0] decodeCode(input logic [7:0] code);
		logic [2:0] res;
		res = 3'h0;
		if (code == CODE_2V10) begin
			res = {1'b1, TH_2V10};
		end else if (code == CODE_2V55) begin
			res = {1'b1, TH_2V55};
		end else if (code == CODE_3V15) begin
			res = {1'b1, TH_3V15};
		end else if (code == CODE_3V80) begin
			res = {1'b1, TH_3V80};
		end
		return res;
	endfunction

	function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
		logic hit;
		hit = 1'b0;
		if (addr == ADDR_THRESH) begin
			hit = 1'b1;
		end else if (addr == ADDR_CAUSE) begin
			hit = 1'b1;
		end else if (addr == ADDR_STATUS) begin
			hit = 1'b1;
		end else if (addr == ADDR_IRQ_STAT) begin
			hit = 1'b1;
		end else if (addr == ADDR_IRQ_MASK) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	rcl_delay_if #(.N(NUM_SRC)) dlyLink ();

	rcl_slow_delay #(.N(NUM_SRC)) u_delay (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.link(dlyLink.dly)
	);

	rcl_state_t stateReg;
	logic [HOLD_W-1:0] holdCntReg;
	logic [7:0] threshReg;
	logic [3:0] causeReg;
	logic [3:0] causeNext;
	logic [1:0] statusReg;
	logic [IRQ_W-1:0] irqStatReg;
	logic [IRQ_W-1:0] irqStatNext;
	logic [IRQ_W-1:0] irqMaskReg;
	logic [31:0] prdataReg;
	logic [31:0] readMux;
	logic [2:0] pinMeta;
	logic [2:0] pinSync;
	logic pdLast;
	logic lircMeta;
	logic lircSync;
	logic lircLast;
	logic [QUAL_W-1:0] qualCntReg;
	logic pcClearReg;
	logic spZeroReg;
	logic [2:0] decoded;
	logic running;
	logic setupPhase;
	logic wrEn;
	logic rdEn;
	logic lvrCond;
	logic lvrQualified;
	logic wdtFull;
	logic wdtWake;
	logic fullStart;
	logic [NUM_SRC-1:0] fire;

	assign running = (stateReg == ST_RUN);
	assign setupPhase = psel && !penable;
	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;
	assign decoded = decodeCode(threshReg);
	assign fire = dlyLink.fire;

	// pins from the analog side and the oscillator pass two flops first
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinMeta <= 3'h0;
			pinSync <= 3'h0;
			pdLast <= 1'b0;
		end else begin
			pinMeta <= {powerDown, supplyAboveMin, supplyLow};
			pinSync <= pinMeta;
			pdLast <= pinSync[PIN_PD];
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lircMeta <= 1'b0;
			lircSync <= 1'b0;
			lircLast <= 1'b0;
		end else begin
			lircMeta <= lircIn;
			lircSync <= lircMeta;
			lircLast <= lircSync;
		end
	end

	assign dlyLink.slowTick = lircSync && !lircLast;

	// low supply must persist above the 0.9V floor, and is ignored in power-down
	assign lvrCond = pinSync[PIN_LOW] && pinSync[PIN_ABOVE_MIN] && !pinSync[PIN_PD];

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			qualCntReg <= '0;
		end else if (!lvrCond) begin
			qualCntReg <= '0;
		end else if (qualCntReg != QUAL_MAX) begin
			qualCntReg <= qualCntReg + QUAL_W'(1);
		end
	end

	assign lvrQualified = (qualCntReg == QUAL_MAX);

	// requests are gated while a reset is held so one event gives one reset
	assign dlyLink.req[CAUSE_BAD_CODE] = running && !decoded[2];
	assign dlyLink.req[CAUSE_LVR] = running && lvrQualified;
	assign dlyLink.req[CAUSE_CTRL_CODE] = running && ctrlCodeFault;
	assign dlyLink.req[CAUSE_WDT_CODE] = running && wdtCodeFault;

	assign wdtFull = running && wdtExpire && !cpuIdle;
	assign wdtWake = running && wdtExpire && cpuIdle;
	assign fullStart = running && ((|fire) || wdtFull);

	// reset sequencer; power-on starts in the hold state itself
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stateReg <= ST_HOLD;
			holdCntReg <= '0;
		end else begin
			case (stateReg)
				ST_RUN: begin
					if (fullStart) begin
						stateReg <= ST_HOLD;
						holdCntReg <= '0;
					end
				end
				ST_HOLD: begin
					if (holdCntReg == HOLD_LAST) begin
						stateReg <= ST_RUN;
					end else begin
						holdCntReg <= holdCntReg + HOLD_W'(1);
					end
				end
				default: begin
					stateReg <= ST_HOLD;
				end
			endcase
		end
	end

	// threshold select: a bad code is restored, a low-voltage reset keeps it
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			threshReg <= THRESH_POR;
		end else if (fire[CAUSE_BAD_CODE]) begin
			threshReg <= THRESH_POR;
		end else if (wrEn && paddr == ADDR_THRESH) begin
			threshReg <= pwdata[7:0];
		end
	end

	// level output only moves on a valid code, so a glitch never reaches the comparator
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			thresholdLevel <= TH_2V10;
		end else if (decoded[2]) begin
			thresholdLevel <= rcl_level_t'(decoded[1:0]);
		end
	end

	// cause flags: hardware sets, software only writes zeros; set beats clear
	always_comb begin
		causeNext = causeReg;
		if (wrEn && paddr == ADDR_CAUSE) begin
			causeNext = causeReg & pwdata[3:0];
		end
		causeNext = causeNext | fire;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			causeReg <= CAUSE_POR;
		end else begin
			causeReg <= causeNext;
		end
	end

	// expiry and power-down flags; a low-voltage reset leaves both alone
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			statusReg <= 2'h0;
		end else if (wdtWake) begin
			statusReg <= 2'h3;
		end else if (wdtFull) begin
			statusReg[STAT_TO] <= 1'b1;
		end else begin
			if (pinSync[PIN_PD] && !pdLast) begin
				statusReg[STAT_PDF] <= 1'b1;
			end else if (wrEn && paddr == ADDR_STATUS && !pwdata[STAT_PDF]) begin
				statusReg[STAT_PDF] <= 1'b0;
			end
			if (wrEn && paddr == ADDR_STATUS && !pwdata[STAT_TO]) begin
				statusReg[STAT_TO] <= 1'b0;
			end
		end
	end

	// sleep wake-up only touches program counter and stack pointer
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pcClearReg <= 1'b0;
			spZeroReg <= 1'b0;
		end else begin
			pcClearReg <= wdtWake;
			spZeroReg <= wdtWake;
		end
	end

	assign coreReset = (stateReg == ST_HOLD);
	assign pcClear = coreReset || pcClearReg;
	assign spZero = spZeroReg;
	assign spTop = coreReset;
	assign intDisable = coreReset;
	assign timersOff = coreReset;
	assign portsInput = coreReset;
	assign wdtClear = coreReset;
	assign wdtRun = running;

	// interrupt status: read clears only what the read reported
	always_comb begin
		irqStatNext = irqStatReg;
		if (rdEn && paddr == ADDR_IRQ_STAT) begin
			irqStatNext = irqStatReg & ~prdataReg[IRQ_W-1:0];
		end
		if (fire[CAUSE_LVR]) begin
			irqStatNext[IRQ_LVR] = 1'b1;
		end
		if (fire[CAUSE_BAD_CODE]) begin
			irqStatNext[IRQ_BAD_CODE] = 1'b1;
		end
		if (wdtFull) begin
			irqStatNext[IRQ_WDT_RESET] = 1'b1;
		end
		if (wdtWake) begin
			irqStatNext[IRQ_WDT_WAKE] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqStatReg <= '0;
		end else begin
			irqStatReg <= irqStatNext;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqMaskReg <= '0;
		end else if (wrEn && paddr == ADDR_IRQ_MASK) begin
			irqMaskReg <= pwdata[IRQ_W-1:0];
		end
	end

	assign irq = |(irqStatReg & irqMaskReg);

	// read data is captured in the setup cycle so it leaves a flop
	always_comb begin
		readMux = 32'h0;
		if (paddr == ADDR_THRESH) begin
			readMux = {24'h0, threshReg};
		end else if (paddr == ADDR_CAUSE) begin
			readMux = {28'h0, causeReg};
		end else if (paddr == ADDR_STATUS) begin
			readMux = {30'h0, statusReg};
		end else if (paddr == ADDR_IRQ_STAT) begin
			readMux = {{(32 - IRQ_W){1'b0}}, irqStatReg};
		end else if (paddr == ADDR_IRQ_MASK) begin
			readMux = {{(32 - IRQ_W){1'b0}}, irqMaskReg};
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdataReg <= 32'h0;
		end else if (setupPhase && !pwrite) begin
			prdataReg <= readMux;
		end
	end

	// zero-wait slave: every access phase completes at once
	assign prdata = prdataReg;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !isMapped(paddr);

endmodule

// file: verif/rcl_far_end.sv
module rcl_far_end #(
	parameter int HALF_NS = 190
) (
	input wire logic lowReq,
	input wire logic floorLow,
	output logic lircIn,
	output logic supplyLow,
	output logic supplyAboveMin
);
	timeunit 1ns;
	timeprecision 1ns;
	// free-running oscillator, phase unrelated to ref_clk so the sync path is exercised
	initial begin
		lircIn = 1'b0;
		forever #(HALF_NS) lircIn = ~lircIn;
	end
	// a supply under the 0.9V floor must not count as a low-voltage dip
	assign supplyLow = lowReq;
	assign supplyAboveMin = !floorLow;
endmodule

// file: verif/rcl_reset_ctrl_chk.sv
module rcl_reset_ctrl_chk #(
	parameter int HOLD_LEN = rcl_pkg::HOLD_CYCLES
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cpuIdle,
	input wire logic wdtExpire,
	input wire logic coreReset,
	input wire logic pcClear,
	input wire logic spZero,
	input wire logic spTop,
	input wire logic intDisable,
	input wire logic timersOff,
	input wire logic portsInput,
	input wire logic wdtClear,
	input wire logic wdtRun
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] holdCnt;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_wake;
		!coreReset && spZero && pcClear ##1 !spZero;
	endsequence
	// length of the current hold, compared when it ends
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			holdCnt <= 8'h00;
		end else if (coreReset) begin
			holdCnt <= holdCnt + 8'h01;
		end else begin
			holdCnt <= 8'h00;
		end
	end
	a_hold_outputs: assert property (coreReset |-> spTop && intDisable && timersOff && portsInput && wdtClear)
		else $error("hold outputs low");
	a_pc_zero: assert property (coreReset |-> pcClear)
		else $error("pc not cleared");
	a_wdt_run: assert property (wdtRun == !coreReset)
		else $error("watchdog run wrong");
	a_wdt_full: assert property (wdtExpire && !cpuIdle && !coreReset |=> coreReset)
		else $error("no full reset");
	a_wdt_sleep: assert property (wdtExpire && cpuIdle && !coreReset |=> s_wake)
		else $error("bad sleep wake");
	a_spzero_cause: assert property ($rose(spZero) |-> $past(wdtExpire) && $past(cpuIdle))
		else $error("stray sp clear");
	a_ignore_hold: assert property (coreReset && wdtExpire |=> !spZero)
		else $error("expiry taken in hold");
	a_hold_len: assert property ($fell(coreReset) |-> holdCnt == 8'(HOLD_LEN))
		else $error("hold length wrong");
endmodule

bind rcl_reset_ctrl rcl_reset_ctrl_chk #(.HOLD_LEN(HOLD_LEN)) rcl_reset_ctrl_chk_i (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .cpuIdle(cpuIdle), .wdtExpire(wdtExpire),
	.coreReset(coreReset), .pcClear(pcClear), .spZero(spZero), .spTop(spTop),
	.intDisable(intDisable), .timersOff(timersOff), .portsInput(portsInput),
	.wdtClear(wdtClear), .wdtRun(wdtRun));

// file: verif/rcl_reset_ctrl_tb_top.sv
module rcl_reset_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rcl_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic cpuIdle = 1'b0;
	logic wdtExpire = 1'b0;
	logic lowReq = 1'b0;
	logic floorLow = 1'b0;
	logic powerDown = 1'b0;
	logic ctrlFault = 1'b0;
	logic wdtFault = 1'b0;
	logic errQ[$];
	logic [31:0] prdata;
	logic pready, pslverr, lircIn, supplyLow, supplyAboveMin, coreReset, irq;
	rcl_level_t thresholdLevel;
	int failures = 0;
	int samplesChecked = 0;
	logic [31:0] expQ[$];
	logic [7:0] codes[4];
	logic [31:0] bad;

	always #25 ref_clk = ~ref_clk;

	rcl_far_end rcl_far_end_i (.lowReq(lowReq), .floorLow(floorLow), .lircIn(lircIn),
		.supplyLow(supplyLow), .supplyAboveMin(supplyAboveMin));
	// short counts keep the run brief; expectations follow these values
	rcl_reset_ctrl #(.QUAL_CYCLES(8), .HOLD_LEN(4)) rcl_reset_ctrl_i (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lircIn(lircIn), .supplyLow(supplyLow), .supplyAboveMin(supplyAboveMin),
		.powerDown(powerDown), .cpuIdle(cpuIdle), .wdtExpire(wdtExpire),
		.ctrlCodeFault(ctrlFault), .wdtCodeFault(wdtFault),
		.thresholdLevel(thresholdLevel), .coreReset(coreReset),
		.pcClear(), .spZero(), .spTop(), .intDisable(), .timersOff(), .portsInput(),
		.wdtClear(), .wdtRun(), .irq(irq));

	task automatic end_of_test();
		// a note never matched by an answer is a mismatch too
		if (expQ.size() != 0 || errQ.size() != 0) failures++;
		if (failures == 0 && samplesChecked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		samplesChecked++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic cmpBit(input logic e, input logic g);
		samplesChecked++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
		errQ.push_back(!(a inside {ADDR_THRESH, ADDR_CAUSE, ADDR_STATUS, ADDR_IRQ_STAT,
			ADDR_IRQ_MASK}));
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		expQ.push_back(e);
		apb(a, 1'b0, 32'h00000000);
	endtask

	task automatic waitRst(input logic v);
		int i;
		i = 0;
		while (coreReset !== v && i < 300) begin
			@(posedge ref_clk);
			i++;
		end
		cmp({31'h0, v}, {31'h0, coreReset});
	endtask

	task automatic wdtPulse(input logic idle);
		cpuIdle <= idle;
		wdtExpire <= 1'b1;
		@(posedge ref_clk);
		wdtExpire <= 1'b0;
		cpuIdle <= 1'b0;
		@(posedge ref_clk);
	endtask

	// read data is taken at the access edge, before the design updates it
	always @(posedge ref_clk) begin
		if (psel === 1'b1 && penable === 1'b1) begin
			cmpBit(1'b1, pready);
		end
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (errQ.size() > 0) cmpBit(errQ.pop_front(), pslverr);
		end
		if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
			if (expQ.size() > 0) cmp(expQ.pop_front(), prdata);
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		end_of_test();
	end

	initial begin
		codes = '{CODE_2V10, CODE_2V55, CODE_3V15, CODE_3V80};
		bad = $urandom(32'hbeef);
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		waitRst(1'b0);
		rd(ADDR_THRESH, 32'h00000055);
		rd(ADDR_STATUS, 32'h00000000);
		for (int i = 0; i < 4; i++) begin
			apb(ADDR_THRESH, 1'b1, {24'h000000, codes[i]});
			rd(ADDR_THRESH, {24'h000000, codes[i]});
			cmp(32'(i), {30'h0, thresholdLevel});
		end
		bad = {24'h000000, 8'($urandom)};
		while (bad[7:0] inside {CODE_2V10, CODE_2V55, CODE_3V15, CODE_3V80}) bad = bad + 32'h1;
		apb(ADDR_THRESH, 1'b1, {24'h000000, bad[7:0]});
		waitRst(1'b1);
		wdtPulse(1'b0);
		waitRst(1'b0);
		rd(ADDR_THRESH, 32'h00000055);
		rd(ADDR_STATUS, 32'h00000000);
		cmp(32'h0, {31'h0, irq});
		apb(ADDR_IRQ_MASK, 1'b1, 32'h0000000F);
		cmp(32'h1, {31'h0, irq});
		rd(ADDR_IRQ_STAT, 32'h00000002);
		cmp(32'h0, {31'h0, irq});
		apb(ADDR_CAUSE, 1'b1, 32'hFFFFFFFF);
		rd(ADDR_CAUSE, 32'h00000002);
		apb(ADDR_CAUSE, 1'b1, 32'h00000000);
		rd(ADDR_CAUSE, 32'h00000000);
		apb(ADDR_THRESH, 1'b1, 32'h00000099);
		lowReq <= 1'b1;
		repeat (4) @(posedge ref_clk);
		lowReq <= 1'b0;
		repeat (60) @(posedge ref_clk);
		cmp(32'h0, {31'h0, coreReset});
		lowReq <= 1'b1;
		waitRst(1'b1);
		lowReq <= 1'b0;
		waitRst(1'b0);
		rd(ADDR_THRESH, 32'h00000099);
		rd(ADDR_CAUSE, 32'h00000004);
		rd(ADDR_STATUS, 32'h00000000);
		wdtPulse(1'b0);
		cmp(32'h1, {31'h0, coreReset});
		waitRst(1'b0);
		rd(ADDR_STATUS, 32'h00000002);
		wdtPulse(1'b1);
		cmp(32'h0, {31'h0, coreReset});
		rd(ADDR_STATUS, 32'h00000003);
		rd(ADDR_CAUSE, 32'h00000004);
		rd(12'h020, 32'h00000000);
		apb(ADDR_STATUS, 1'b1, 32'h00000000);
		rd(ADDR_STATUS, 32'h00000000);
		// a dip while powered down must be ignored; the entry sets the power-down flag
		powerDown <= 1'b1;
		lowReq <= 1'b1;
		repeat (60) @(posedge ref_clk);
		cmp(32'h0, {31'h0, coreReset});
		rd(ADDR_STATUS, 32'h00000001);
		// both pins pass their synchroniser lanes in step, so they switch together
		powerDown <= 1'b0;
		floorLow <= 1'b1;
		repeat (60) @(posedge ref_clk);
		cmp(32'h0, {31'h0, coreReset});
		lowReq <= 1'b0;
		floorLow <= 1'b0;
		ctrlFault <= 1'b1;
		wdtFault <= 1'b1;
		waitRst(1'b1);
		ctrlFault <= 1'b0;
		wdtFault <= 1'b0;
		waitRst(1'b0);
		rd(ADDR_CAUSE, 32'h0000000D);
		rd(ADDR_STATUS, 32'h00000001);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		waitRst(1'b0);
		rd(ADDR_STATUS, 32'h00000000);
		rd(ADDR_THRESH, 32'h00000055);
		rd(ADDR_CAUSE, 32'h00000000);
		end_of_test();
	end
endmodule
